/* qdfd_frame_decoder.sv */
/*
 * Frame decoder top: splits received serial words into their fields,
 * keeps the channel code, range, power and control registers, maps
 * channel codes to signed output levels and offers status over APB.
 * Assumes an APB master on ref_clk and a host driving the serial link.
 */
// Our own choices: the APB interface to the registers and the register addresses.
// Overview of operation
// - Each transfer is one 24-bit word, held until complete.
// - Bits arrive MSB first, bit 23 first, bit 0 last.
// - Word splits into rw, reserved, select, address and data fields.
// - Top bit chooses read or write of the selected register.
// - Select 000 data, 001 range, 010 power, 011 control.
// - Address 000..011 picks channel A..D; 100 picks all four.
// - Every register can be written and read back.
// - Bipolar offset binary: 800h is zero, 2048 steps each half.
// - Bipolar twos complement: zero is zero, 7FFh top, 800h bottom.
// - Unipolar: straight binary, code over 4096 of full scale.
// - Channel code is data bits 15..4; bits 3..0 ignored.
// - Range codes 000..010 unipolar, 011..101 bipolar.
`timescale 1ns/1ps
module qdfd_frame_decoder
    import qdfd_pkg::*;
(
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          serialClk,
    input  wire logic                          frameSyncN,
    input  wire logic                          serial_data_in,
    input  wire logic                          coding_select,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [qdfd_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic [31:0]                        prdata,
    output logic                               pready,
    output logic                               pslverr,
    output logic [qdfd_pkg::NUM_CH-1:0][qdfd_pkg::LEVEL_W-1:0] chanLevel,
    output logic [qdfd_pkg::NUM_CH-1:0]        chanBipolar
);
    import qdfd_pkg::*;

    // ********************************************************
    // Helper functions
    // ********************************************************
    function automatic logic isBipolar(input logic [RANGE_W-1:0] r);
        return r >= RANGE_BIP_LO && r <= RANGE_BIP_HI;
    endfunction : isBipolar

    function automatic logic [LEVEL_W-1:0] codeToLevel(
        input logic [CODE_W-1:0]  code,
        input logic [RANGE_W-1:0] r,
        input logic               twos);
        logic [LEVEL_W-1:0] lvl;
        lvl = {1'b0, code};
        if (!isBipolar(r))
            lvl = {1'b0, code};
        else if (twos)
            lvl = {code[CODE_W-1], code};
        else
            lvl = {1'b0, code} - HALF_SPAN;
        return lvl;
    endfunction : codeToLevel

    function automatic logic [CODE_W-1:0] clearCode(
        input logic [RANGE_W-1:0] r,
        input logic               clrSel,
        input logic               twos);
        if (!clrSel)
            return twos || !isBipolar(r) ? CODE_ZERO : CODE_MID;
        return isBipolar(r) && !twos ? CODE_ZERO : CODE_MID;
    endfunction : clearCode

    // ********************************************************
    // Link receiver
    // ********************************************************
    logic              wordValid;
    logic              wordDrop;
    logic              frameActive;
    logic [WORD_W-1:0] word;

    qdfd_link_rx u_rx (
        .ref_clk        (ref_clk),
        .sys_rst        (sys_rst),
        .serialClk      (serialClk),
        .frameSyncN     (frameSyncN),
        .serial_data_in (serial_data_in),
        .wordValid      (wordValid),
        .wordData       (word),
        .wordDrop       (wordDrop),
        .frameActive    (frameActive)
    );

    // ********************************************************
    // Field split
    // ********************************************************
    logic [1:0]         control_q;
    logic               wordRead;
    logic               rsvdBit;
    logic [2:0]         regSel;
    logic [2:0]         chanAddr;
    logic [DATA_W-1:0]  dataField;
    logic [CODE_W-1:0]  newCode;
    logic               act;
    logic [1:0]         codingSync_q;
    logic               twosSel;

    assign wordRead  = word[BIT_RW];
    assign rsvdBit   = word[BIT_RSVD];
    assign regSel    = word[SEL_HI:SEL_LO];
    assign chanAddr  = word[ADDR_HI:ADDR_LO];
    assign dataField = word[DATA_HI:0];
    assign newCode   = word[DATA_HI:CODE_LO];
    assign act       = wordValid && control_q[CTL_ENABLE];

    always_ff @(posedge ref_clk)
        codingSync_q <= sys_rst ? 2'h0 : {codingSync_q[0], coding_select};
    assign twosSel = codingSync_q[1];

    // ********************************************************
    // Serial registers
    // ********************************************************
    logic [NUM_CH-1:0][CODE_W-1:0]  chanCode_q;
    logic [NUM_CH-1:0][RANGE_W-1:0] chanRange_q;
    logic [DATA_W-1:0]              power_q;
    logic [CTRLF_W-1:0]             ctrlFn_q;
    logic [DATA_W-1:0]              readback_q;
    logic                           badRange_q;
    logic                           rsvdErr_q;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
            logic hit;
            assign hit = chanAddr == 3'(ch) || chanAddr == ADDR_ALL;

            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    chanCode_q[ch]  <= CODE_ZERO;
                    chanRange_q[ch] <= '0;
                end else if (act && !wordRead) begin
                    if (regSel == SEL_DAC && hit)
                        chanCode_q[ch] <= newCode;
                    else if (regSel == SEL_RANGE && hit &&
                             dataField[RANGE_W-1:0] <= RANGE_BIP_HI)
                        chanRange_q[ch] <= dataField[RANGE_W-1:0];
                    else if (regSel == SEL_CTRL && chanAddr == CTRL_CLEAR)
                        chanCode_q[ch] <= clearCode(chanRange_q[ch],
                            ctrlFn_q[CLRSEL_BIT], twosSel);
                end
            end

            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    chanLevel[ch]   <= '0;
                    chanBipolar[ch] <= 1'b0;
                end else begin
                    chanLevel[ch] <= codeToLevel(chanCode_q[ch],
                        chanRange_q[ch], twosSel);
                    chanBipolar[ch] <= isBipolar(chanRange_q[ch]);
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            power_q  <= '0;
            ctrlFn_q <= '0;
        end else if (act && !wordRead) begin
            if (regSel == SEL_POWER)
                power_q <= dataField;
            else if (regSel == SEL_CTRL && chanAddr == CTRL_SET)
                ctrlFn_q <= dataField[CTRLF_W-1:0];
        end
    end

    // Readback of the selected register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            readback_q <= '0;
        end else if (act && wordRead) begin
            unique case (regSel)
                SEL_DAC:
                    readback_q <= {chanCode_q[chanAddr[1:0]],
                                   CODE_LO'(0)};
                SEL_RANGE:
                    readback_q <= DATA_W'(chanRange_q[chanAddr[1:0]]);
                SEL_POWER:
                    readback_q <= power_q;
                default:
                    readback_q <= DATA_W'(ctrlFn_q);
            endcase
        end
    end

    // ********************************************************
    // APB slave
    // ********************************************************
    logic [CNT32_W-1:0] wordCnt_q;
    logic [CNT32_W-1:0] dropCnt_q;
    logic [WORD_W-1:0]  lastWord_q;
    logic               apbWr;
    logic               apbRd;
    logic               mapped;
    logic               levelHit;

    assign apbWr    = psel && penable && pwrite;
    assign apbRd    = psel && !penable && !pwrite;
    assign levelHit = paddr >= REG_LEVEL0 &&
                      paddr < REG_LEVEL0 + ADDR_W'(4 * NUM_CH) &&
                      paddr[1:0] == 2'h0;
    assign mapped   = paddr == REG_CONTROL || paddr == REG_STATUS ||
                      paddr == REG_LASTWORD || paddr == REG_READBACK ||
                      paddr == REG_WORDCNT || paddr == REG_DROPCNT ||
                      levelHit;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;

    always_ff @(posedge ref_clk) begin
        if (sys_rst)
            control_q <= CONTROL_RESET;
        else if (apbWr && paddr == REG_CONTROL)
            control_q <= pwdata[1:0];
        else
            control_q[CTL_CLRCNT] <= 1'b0;
    end

    // Status flags: set wins over software clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rsvdErr_q  <= 1'b0;
            badRange_q <= 1'b0;
        end else begin
            if (act && rsvdBit)
                rsvdErr_q <= 1'b1;
            else if (apbWr && paddr == REG_STATUS && pwdata[STS_RSVDERR])
                rsvdErr_q <= 1'b0;
            if (act && !wordRead && regSel == SEL_RANGE &&
                dataField[RANGE_W-1:0] > RANGE_BIP_HI)
                badRange_q <= 1'b1;
            else if (apbWr && paddr == REG_STATUS && pwdata[STS_BADRANGE])
                badRange_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || control_q[CTL_CLRCNT]) begin
            wordCnt_q  <= '0;
            dropCnt_q  <= '0;
        end else begin
            if (act)
                wordCnt_q <= wordCnt_q + CNT32_W'(1);
            if (wordDrop)
                dropCnt_q <= dropCnt_q + CNT32_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst)
            lastWord_q <= '0;
        else if (act)
            lastWord_q <= word;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prdata <= '0;
        end else if (apbRd) begin
            prdata <= '0;
            if (paddr == REG_CONTROL)
                prdata <= 32'(control_q);
            else if (paddr == REG_STATUS)
                prdata <= 32'({badRange_q, rsvdErr_q, frameActive});
            else if (paddr == REG_LASTWORD)
                prdata <= 32'(lastWord_q);
            else if (paddr == REG_READBACK)
                prdata <= 32'(readback_q);
            else if (paddr == REG_WORDCNT)
                prdata <= 32'(wordCnt_q);
            else if (paddr == REG_DROPCNT)
                prdata <= 32'(dropCnt_q);
            else if (levelHit)
                prdata <= 32'(chanLevel[paddr[3:2]]);
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    dac_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        act && !wordRead && regSel == SEL_DAC && chanAddr == 3'h1
        |=> chanCode_q[1] == $past(word[DATA_HI:CODE_LO]))
        else $error("channel B code not written");

    all_chan_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        act && !wordRead && regSel == SEL_DAC && chanAddr == ADDR_ALL
        |=> chanCode_q[0] == chanCode_q[3] && chanCode_q[2] == chanCode_q[1])
        else $error("broadcast write missed a channel");

    read_keeps_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        act && wordRead |=> $stable(chanCode_q) && $stable(power_q))
        else $error("read changed register contents");

    range_back_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        act && wordRead && regSel == SEL_RANGE && chanAddr == 3'h1
        |=> readback_q == DATA_W'($past(chanRange_q[1])))
        else $error("range readback wrong");

    sel_power_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        act && !wordRead && regSel == SEL_POWER
        |=> power_q == $past(dataField) && $stable(chanRange_q))
        else $error("power register write wrong");

    offset_bin_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        isBipolar(chanRange_q[1]) && !twosSel &&
        chanCode_q[1] == CODE_MID ##1 $stable(chanCode_q[1])
        |-> chanLevel[1] == '0)
        else $error("offset binary midscale not zero");

    twos_comp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        isBipolar(chanRange_q[1]) && twosSel &&
        chanCode_q[1] == CODE_MID ##1 $stable(chanCode_q[1])
        |-> chanLevel[1] == {1'b1, CODE_MID})
        else $error("twos complement bottom wrong");

    unipolar_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !isBipolar(chanRange_q[3]) ##1 $stable(chanCode_q[3]) &&
        $stable(chanRange_q[3]) |-> chanLevel[3] == {1'b0, chanCode_q[3]})
        else $error("unipolar level not straight binary");

    drop_ignored_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wordDrop |=> $stable(chanCode_q) && $stable(lastWord_q))
        else $error("partial word acted on");

endmodule : qdfd_frame_decoder

/* qdfd_host_model.sv */
/*
 * Host model for the serial link: frames 24-bit words MSB first.
 * Assumes ref_clk at 250 MHz; link clock period is 40 ref_clk cycles.
 */
`timescale 1ns/1ps
module qdfd_host_model (
    input  wire logic ref_clk,
    output logic      serialClk,
    output logic      frameSyncN,
    output logic      serial_data_in
);
    initial begin
        serialClk      = 1'b1;
        frameSyncN     = 1'b1;
        serial_data_in = 1'b0;
    end
    // ********************************************************
    // Frame driver: data set on rise, taken on fall
    // ********************************************************
    task sendWord(input logic [23:0] w, input int n);
        w[22] = 1'b0;
        @(posedge ref_clk);
        frameSyncN <= 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_data_in <= w[23-i];
            serialClk      <= 1'b1;
            repeat (20) @(posedge ref_clk);
            serialClk <= 1'b0;
            repeat (20) @(posedge ref_clk);
        end
        serialClk <= 1'b1;
        repeat (20) @(posedge ref_clk);
        frameSyncN     <= 1'b1;
        serial_data_in <= ~serial_data_in;
        repeat (12) @(posedge ref_clk);
    endtask : sendWord
endmodule : qdfd_host_model

/* qdfd_link_rx.sv */
/*
 * Serial link receiver: synchronises the link clock, frame sync and
 * serial data to ref_clk, shifts bits in on falling link-clock edges
 * during a frame and delivers whole 24-bit words at frame end.
 * Assumes the link clock is much slower than ref_clk.
 */
`timescale 1ns/1ps
module qdfd_link_rx
    import qdfd_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic                serialClk,
    input  wire logic                frameSyncN,
    input  wire logic                serial_data_in,
    output logic                     wordValid,
    output logic [qdfd_pkg::WORD_W-1:0] wordData,
    output logic                     wordDrop,
    output logic                     frameActive
);
    import qdfd_pkg::*;

    // ********************************************************
    // Synchronisers
    // ********************************************************
    logic [2:0]        clkSync_q;
    logic [2:0]        syncSync_q;
    logic [2:0]        dataSync_q;
    logic [CNT_W-1:0]  bitCnt_q;
    logic [WORD_W-1:0] shift_q;
    logic              clkFall;
    logic              frameEnd;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            clkSync_q  <= 3'h7;
            syncSync_q <= 3'h7;
            dataSync_q <= 3'h0;
        end else begin
            clkSync_q  <= {clkSync_q[1:0], serialClk};
            syncSync_q <= {syncSync_q[1:0], frameSyncN};
            dataSync_q <= {dataSync_q[1:0], serial_data_in};
        end
    end

    assign frameActive = ~syncSync_q[1];
    assign clkFall     = clkSync_q[2] & ~clkSync_q[1];
    assign frameEnd    = ~syncSync_q[2] & syncSync_q[1];

    // ********************************************************
    // Shift and count
    // ********************************************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            shift_q  <= '0;
            bitCnt_q <= '0;
        end else if (!frameActive) begin
            bitCnt_q <= '0;
        end else if (clkFall) begin
            shift_q <= {shift_q[WORD_W-2:0], dataSync_q[1]};
            if (bitCnt_q <= CNT_W'(WORD_W))
                bitCnt_q <= bitCnt_q + CNT_W'(1);
        end
    end

    // ********************************************************
    // Word delivery
    // ********************************************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wordValid <= 1'b0;
            wordDrop  <= 1'b0;
            wordData  <= '0;
        end else begin
            wordValid <= frameEnd && bitCnt_q == CNT_W'(WORD_W);
            wordDrop  <= frameEnd && bitCnt_q != CNT_W'(WORD_W);
            if (frameEnd && bitCnt_q == CNT_W'(WORD_W))
                wordData <= shift_q;
        end
    end

    frame_len_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wordValid |-> $past(bitCnt_q) == CNT_W'(WORD_W))
        else $error("word delivered without 24 bits");

    drop_short_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(syncSync_q[2]) && $past(bitCnt_q, 2) != CNT_W'(WORD_W)
        |-> wordDrop && !wordValid)
        else $error("incomplete frame not discarded");

endmodule : qdfd_link_rx

/* qdfd_pkg.sv */
/*
 * Shared constants for the quad converter serial frame decoder: word
 * layout, register-select and channel codes, range codes, the register
 * map of the status and control registers, and reset values.
 * Assumes nothing of its surroundings.
 */
package qdfd_pkg;

    // ********************************************************
    // Serial word layout
    // ********************************************************
    localparam int WORD_W     = 24;
    localparam int CNT_W      = 5;
    localparam int BIT_RW     = 23;
    localparam int BIT_RSVD   = 22;
    localparam int SEL_HI     = 21;
    localparam int SEL_LO     = 19;
    localparam int ADDR_HI    = 18;
    localparam int ADDR_LO    = 16;
    localparam int DATA_HI    = 15;
    localparam int CODE_LO    = 4;
    localparam int CODE_W     = 12;
    localparam int LEVEL_W    = 13;
    localparam int DATA_W     = 16;
    localparam int RANGE_W    = 3;
    localparam int CTRLF_W    = 4;
    localparam int NUM_CH     = 4;

    // ********************************************************
    // Field codes
    // ********************************************************
    localparam logic [2:0] SEL_DAC    = 3'h0;
    localparam logic [2:0] SEL_RANGE  = 3'h1;
    localparam logic [2:0] SEL_POWER  = 3'h2;
    localparam logic [2:0] SEL_CTRL   = 3'h3;
    localparam logic [2:0] ADDR_ALL   = 3'h4;
    localparam logic [2:0] CTRL_NOP   = 3'h0;
    localparam logic [2:0] CTRL_SET   = 3'h1;
    localparam logic [2:0] CTRL_CLEAR = 3'h4;
    localparam logic [2:0] CTRL_LOAD  = 3'h5;
    localparam logic [2:0] RANGE_BIP_LO = 3'h3;
    localparam logic [2:0] RANGE_BIP_HI = 3'h5;
    localparam int         CLRSEL_BIT   = 1;

    // ********************************************************
    // Codes and levels
    // ********************************************************
    localparam logic [CODE_W-1:0]  CODE_ZERO = 12'h000;
    localparam logic [CODE_W-1:0]  CODE_MID  = 12'h800;
    localparam logic [LEVEL_W-1:0] HALF_SPAN = 13'h0800;

    // ********************************************************
    // Register map (byte addresses)
    // ********************************************************
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  REG_CONTROL   = 8'h00;
    localparam logic [7:0]  REG_STATUS    = 8'h04;
    localparam logic [7:0]  REG_LASTWORD  = 8'h08;
    localparam logic [7:0]  REG_READBACK  = 8'h0C;
    localparam logic [7:0]  REG_WORDCNT   = 8'h10;
    localparam logic [7:0]  REG_DROPCNT   = 8'h14;
    localparam logic [7:0]  REG_LEVEL0    = 8'h20;
    localparam int          CTL_ENABLE    = 0;
    localparam int          CTL_CLRCNT    = 1;
    localparam int          STS_ACTIVE    = 0;
    localparam int          STS_RSVDERR   = 1;
    localparam int          STS_BADRANGE  = 2;
    localparam logic [1:0]  CONTROL_RESET = 2'h1;
    localparam int          CNT32_W       = 16;

endpackage : qdfd_pkg

/* test_quad_dac_serial_frame_decoder.sv */
/*
 * Self-checking bench for the frame decoder: APB master and host model.
 * Assumes the zero-wait APB slave and level timing of the design.
 */
`timescale 1ns/1ps
module test_quad_dac_serial_frame_decoder;
    import qdfd_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic codingSel = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, lastErr;
    logic [NUM_CH-1:0][LEVEL_W-1:0] chanLevel;
    logic [NUM_CH-1:0] chanBipolar;
    logic sClk, fSyncN, sData;
    int num_errors = 0;
    int checked = 0;
    int cyc = 0;
    always #2 ref_clk = ~ref_clk;
    qdfd_host_model i_host (.ref_clk(ref_clk), .serialClk(sClk),
        .frameSyncN(fSyncN), .serial_data_in(sData));
    qdfd_frame_decoder i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .serialClk(sClk), .frameSyncN(fSyncN), .serial_data_in(sData),
        .coding_select(codingSel), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chanLevel(chanLevel),
        .chanBipolar(chanBipolar));
    // ********************************************************
    // Shared tasks
    // ********************************************************
    task wrap_up;
        $display("errors=%0d checked=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task apbXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd      = prdata;
        lastErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apbXfer
    task apbRead(input logic [7:0] a);
        apbXfer(1'b0, a, 32'h0);
    endtask : apbRead
    task lvl(input int ch, input logic [12:0] e);
        chk({19'h0, chanLevel[ch]}, {19'h0, e});
    endtask : lvl
    // ********************************************************
    // Scenarios
    // ********************************************************
    task tReset;
        apbRead(REG_CONTROL);
        chk(rd, 32'h1);
        lvl(0, 13'h0000);
    endtask : tReset
    task tUnipolar;
        i_host.sendWord(24'h00800F, 24);
        lvl(0, 13'h0800);
        apbRead(REG_LASTWORD);
        chk(rd, 32'h0000800F);
    endtask : tUnipolar
    task tBipolar;
        i_host.sendWord(24'h090003, 24);
        i_host.sendWord(24'h018000, 24);
        chk({31'h0, chanBipolar[1]}, 32'h1);
        lvl(1, 13'h0000);
        @(posedge ref_clk);
        codingSel <= 1'b1;
        repeat (4) @(posedge ref_clk);
        lvl(1, 13'h1800);
        codingSel <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : tBipolar
    task tAll;
        i_host.sendWord(24'h04FFF0, 24);
        for (int c = 0; c < NUM_CH; c++) begin
            lvl(c, (c == 1) ? 13'h07FF : 13'h0FFF);
        end
    endtask : tAll
    task tDrop;
        i_host.sendWord(24'h000000, 23);
        lvl(0, 13'h0FFF);
        apbRead(REG_DROPCNT);
        chk(rd, 32'h1);
    endtask : tDrop
    task tReadback;
        i_host.sendWord(24'h800000, 24);
        apbRead(REG_READBACK);
        chk(rd, 32'h0000FFF0);
        lvl(0, 13'h0FFF);
    endtask : tReadback
    task tUnmapped;
        apbRead(8'hFC);
        chk({31'h0, lastErr}, 32'h1);
        chk(rd, 32'h0);
    endtask : tUnmapped
    task tRegs;
        i_host.sendWord(24'h100025, 24);
        i_host.sendWord(24'h900000, 24);
        apbRead(REG_READBACK);
        chk(rd, 32'h00000025);
        i_host.sendWord(24'h890000, 24);
        apbRead(REG_READBACK);
        chk(rd, 32'h00000003);
    endtask : tRegs
    task tStatus;
        i_host.sendWord(24'h0A0007, 24);
        chk({31'h0, chanBipolar[2]}, 32'h0);
        apbRead(REG_STATUS);
        chk(rd, 32'h4);
        apbXfer(1'b1, REG_STATUS, 32'h4);
        apbXfer(1'b1, REG_CONTROL, 32'h0);
        i_host.sendWord(24'h010000, 24);
        lvl(1, 13'h07FF);
        apbXfer(1'b1, REG_CONTROL, 32'h3);
        apbRead(REG_STATUS);
        chk(rd, 32'h0);
        apbRead(REG_WORDCNT);
        chk(rd, 32'h0);
        apbRead(REG_CONTROL);
        chk(rd, 32'h1);
    endtask : tStatus
    task tClear;
        i_host.sendWord(24'h190002, 24);
        i_host.sendWord(24'h1C0000, 24);
        lvl(0, 13'h0800);
        lvl(1, 13'h1800);
        lvl(2, 13'h0800);
    endtask : tClear
    // ********************************************************
    // Run control
    // ********************************************************
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up;
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        tReset;
        tUnipolar;
        tBipolar;
        tAll;
        tDrop;
        tReadback;
        tRegs;
        tStatus;
        tClear;
        tUnmapped;
        wrap_up;
    end
endmodule : test_quad_dac_serial_frame_decoder
